// >>> hw/adcs_buf2.v
`timescale 1ns/1ns
module adcs_buf2 #(
  parameter WIDTH = 16
) (
  input  wire             ref_clk,
  input  wire             rst_b,
  input  wire             clr,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] d0_q;
  reg [WIDTH-1:0] d1_q;
  reg [1:0]       cnt_q;
  wire            push;
  wire            pop;

  assign in_ready  = (cnt_q != 2'd2);
  assign out_valid = (cnt_q != 2'd0);
  assign out_data  = d0_q;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      d0_q  <= {WIDTH{1'b0}};
      d1_q  <= {WIDTH{1'b0}};
      cnt_q <= 2'd0;
    end else if (clr) begin
      cnt_q <= 2'd0;
    end else begin
      if (pop) begin
        d0_q <= (push && cnt_q == 2'd1) ? in_data : d1_q;
        if (push && cnt_q == 2'd2)
          d1_q <= in_data;
      end else if (push) begin
        if (cnt_q == 2'd0)
          d0_q <= in_data;
        else
          d1_q <= in_data;
      end
      if (push && !pop)
        cnt_q <= cnt_q + 2'd1;
      else if (pop && !push)
        cnt_q <= cnt_q - 2'd1;
    end
  end
endmodule

// >>> hw/adcs_defines.vh
`ifndef ADCS_DEFINES_VH
`define ADCS_DEFINES_VH

// Register word indices (byte address = index*2 + byte)
`define ADCS_IDX_CFG      4'h8
`define ADCS_IDX_IEN      4'h9
`define ADCS_IDX_STAT     4'ha
`define ADCS_IDX_TIMER    4'hb
`define ADCS_IDX_FIFO     4'hc
`define ADCS_IDX_LIMSTAT  4'hd

// Instruction section zero fields
`define ADCS_I_LOOP       0
`define ADCS_I_PAUSE      1
`define ADCS_I_POS        2
`define ADCS_I_NEG        5
`define ADCS_I_TIMER      9
`define ADCS_I_SEL8       10
`define ADCS_I_WDOG       11
`define ADCS_I_ACQ        12

// Limit section fields
`define ADCS_L_SIGN       8
`define ADCS_L_GT         9

// Configuration fields
`define ADCS_C_START      0
`define ADCS_C_RESET      1
`define ADCS_C_AZ         2
`define ADCS_C_CAL        3
`define ADCS_C_SEC        8

// Interrupt enable fields
`define ADCS_E_INSTR      8
`define ADCS_E_LEVEL      11

// Interrupt source numbers
`define ADCS_INT_LIMIT    0
`define ADCS_INT_INSTR    1
`define ADCS_INT_LEVEL    2
`define ADCS_INT_AZ       3
`define ADCS_INT_CAL      4
`define ADCS_INT_PAUSE    5
`define ADCS_INT_FULL     6
`define ADCS_INT_LOOP     7

// Timer
`define ADCS_TMR_SHIFT    5
`define ADCS_TMR_OVH      22'd2

`define ADCS_CFG_RST      16'h0000
`define ADCS_IEN_RST      16'h0000
`define ADCS_TIMER_RST    16'h0000

`endif

// >>> hw/adcs_sequencer.v
`timescale 1ns/1ns
`include "adcs_defines.vh"
module adcs_sequencer #(
  parameter FIFO_DEPTH = 32,
  parameter PTR_W      = 5
) (
  input  wire        ref_clk,
  input  wire        rst_b,
  input  wire        cs_b,
  input  wire        rd_b,
  input  wire        wr_b,
  input  wire [4:0]  addr,
  input  wire [15:0] data_in,
  output wire [15:0] data_out,
  output wire        data_oe_b,
  input  wire        bus_width_select,
  output wire        irq_b,
  output wire        conv_req,
  output wire        conv_sel8,
  output wire [3:0]  conv_acq,
  output wire [2:0]  conv_pos,
  output wire [2:0]  conv_neg,
  input  wire        conv_done,
  input  wire [12:0] conv_result,
  output wire        cal_req,
  output wire        az_req,
  input  wire        cal_done,
  input  wire        az_done
);
  localparam S_IDLE = 3'd0;
  localparam S_WAIT = 3'd1;
  localparam S_CONV = 3'd2;
  localparam S_PUSH = 3'd3;
  localparam S_NEXT = 3'd4;

  // Byte-lane merge for 8-bit bus writes
  function [15:0] merge;
    input [15:0] old;
    input [15:0] nw;
    input        wide;
    input        hi;
    begin
      if (wide)
        merge = nw;
      else if (hi)
        merge = {nw[7:0], old[7:0]};
      else
        merge = {old[15:8], nw[7:0]};
    end
  endfunction

  // Signed 8-bit + sign compare against a limit section
  function crossed;
    input [8:0]  val;
    input [15:0] lim;
    reg   [8:0]  l;
    begin
      l = {lim[`ADCS_L_SIGN], lim[7:0]};
      if (lim[`ADCS_L_GT])
        crossed = $signed(val) > $signed(l);
      else
        crossed = $signed(val) < $signed(l);
    end
  endfunction

  // Pin synchronisers
  reg  [24:0] sy1_q;
  reg  [24:0] sy2_q;
  wire        bw_s;
  wire        cs_s;
  wire        rd_s;
  wire        wr_s;
  wire [4:0]  addr_s;
  wire [15:0] din_s;

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sy1_q <= 25'h0e00000;
      sy2_q <= 25'h0e00000;
    end else begin
      sy1_q <= {bus_width_select, cs_b, rd_b, wr_b, addr, data_in};
      sy2_q <= sy1_q;
    end
  end

  assign bw_s   = sy2_q[24];
  assign cs_s   = ~sy2_q[23];
  assign rd_s   = ~sy2_q[22];
  assign wr_s   = ~sy2_q[21];
  assign addr_s = sy2_q[20:16];
  assign din_s  = sy2_q[15:0];

  // Bus width strap: high selects the byte-wide bus
  wire       wide = ~bw_s;
  wire [3:0] idx_s = addr_s[4:1];
  wire       hi_s = addr_s[0];

  // Registers
  reg [15:0] imem [0:31];
  reg [15:0] cfg_q;
  reg [15:0] ien_q;
  reg [15:0] timer_q;
  reg [7:0]  stat_q;
  reg [15:0] limstat_q;
  reg        cal_q;
  reg        az_q;
  reg        irq_q;

  // Host access tracking
  reg        rd_prev_q;
  reg        wpend_q;
  reg [4:0]  wa_q;
  reg [15:0] wd_q;
  reg [15:0] dout_q;
  reg        oe_b_q;

  wire       rd_fall = rd_s & ~rd_prev_q & cs_s;
  wire       commit  = wpend_q & ~wr_s;
  wire [3:0] widx    = wa_q[4:1];
  wire       whi     = wa_q[0];
  wire [1:0] sec     = cfg_q[`ADCS_C_SEC+1:`ADCS_C_SEC];
  wire       soft_rst = commit && widx == `ADCS_IDX_CFG && (wide || !whi) && wd_q[`ADCS_C_RESET];
  // A read of the high byte, or a word read, completes the access
  wire       rd_done = rd_fall & (wide | hi_s);
  wire       rd_low  = rd_fall & (wide | ~hi_s);

  // Result FIFO
  reg [15:0]      fmem [0:FIFO_DEPTH-1];
  reg [PTR_W:0]   wptr_q;
  reg [PTR_W:0]   rptr_q;
  wire [PTR_W:0]  fcnt  = wptr_q - rptr_q;
  wire            fempty = (fcnt == {(PTR_W+1){1'b0}});
  wire            ffull  = (fcnt == FIFO_DEPTH[PTR_W:0]);
  wire            bo_valid;
  wire [15:0]     bo_data;
  wire            fpush = bo_valid & ~ffull;
  wire            fpop  = rd_done && idx_s == `ADCS_IDX_FIFO && !fempty;

  // Sequencer
  reg [2:0]  st_q;
  reg [2:0]  slot_q;
  reg [21:0] cnt_q;
  reg [12:0] res_q;
  reg        creq_q;
  reg        bi_valid;
  wire       bi_ready;
  reg  [7:0] ev;

  wire [15:0] iw  = imem[{slot_q, 2'd0}];
  wire [15:0] lm1 = imem[{slot_q, 2'd1}];
  wire [15:0] lm2 = imem[{slot_q, 2'd2}];
  wire        halt = cs_s;
  wire        run  = cfg_q[`ADCS_C_START];
  wire [8:0]  val8 = res_q[12:4];
  wire        hit1 = crossed(val8, lm1);
  wire        hit2 = crossed(val8, lm2);
  wire [15:0] rword = iw[`ADCS_I_SEL8] ?
                      {slot_q, {4{res_q[12]}}, res_q[12:4]} : {slot_q, res_q};

  adcs_buf2 #(
    .WIDTH(16)
  ) u_buf (
    .ref_clk  (ref_clk),
    .rst_b    (rst_b),
    .clr      (soft_rst),
    .in_valid (bi_valid),
    .in_ready (bi_ready),
    .in_data  (rword),
    .out_valid(bo_valid),
    .out_ready(~ffull),
    .out_data (bo_data)
  );

  always @* begin
    bi_valid = (st_q == S_PUSH) & ~halt;
  end

  // Interrupt events
  wire [4:0] lvl = ien_q[15:`ADCS_E_LEVEL];
  always @* begin
    ev = 8'h00;
    ev[`ADCS_INT_LEVEL] = (lvl != 5'd0) && (fcnt >= {1'b0, lvl});
    ev[`ADCS_INT_FULL]  = ffull;
    ev[`ADCS_INT_CAL]   = cal_q & cal_done;
    ev[`ADCS_INT_AZ]    = az_q & az_done;
    if (st_q == S_NEXT && !halt) begin
      ev[`ADCS_INT_LIMIT] = iw[`ADCS_I_WDOG] & (hit1 | hit2);
      ev[`ADCS_INT_INSTR] = (slot_q == ien_q[`ADCS_E_INSTR+2:`ADCS_E_INSTR]);
      ev[`ADCS_INT_PAUSE] = iw[`ADCS_I_PAUSE];
      ev[`ADCS_INT_LOOP]  = iw[`ADCS_I_LOOP];
    end
  end

  // Read data mux
  reg [15:0] rsel;
  always @* begin
    rsel = 16'h0000;
    if (!idx_s[3]) begin
      if (sec != 2'd3)
        rsel = imem[{idx_s[2:0], sec}];
    end else begin
      case (idx_s)
        `ADCS_IDX_CFG:     rsel = {cfg_q[15:4], cal_q, az_q, 1'b0, cfg_q[0]};
        `ADCS_IDX_IEN:     rsel = ien_q;
        `ADCS_IDX_STAT:    rsel = {fcnt[PTR_W:0], 2'b00, stat_q};
        `ADCS_IDX_TIMER:   rsel = timer_q;
        `ADCS_IDX_FIFO:    rsel = fempty ? 16'h0000 : fmem[rptr_q[PTR_W-1:0]];
        `ADCS_IDX_LIMSTAT: rsel = limstat_q;
        default:           rsel = 16'h0000;
      endcase
    end
  end

  // Host bus side
  integer i;
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_prev_q <= 1'b0;
      wpend_q   <= 1'b0;
      wa_q      <= 5'h00;
      wd_q      <= 16'h0000;
      dout_q    <= 16'h0000;
      oe_b_q    <= 1'b1;
      cfg_q     <= `ADCS_CFG_RST;
      ien_q     <= `ADCS_IEN_RST;
      timer_q   <= `ADCS_TIMER_RST;
      cal_q     <= 1'b0;
      az_q      <= 1'b0;
      for (i = 0; i < 32; i = i + 1)
        imem[i] <= 16'h0000;
    end else begin
      rd_prev_q <= rd_s;
      oe_b_q    <= ~(rd_s & cs_s);
      if (rd_fall)
        dout_q <= wide ? rsel : (hi_s ? {8'h00, rsel[15:8]} : {8'h00, rsel[7:0]});
      if (wr_s && cs_s) begin
        wpend_q <= 1'b1;
        wa_q    <= addr_s;
        wd_q    <= din_s;
      end else if (commit) begin
        wpend_q <= 1'b0;
      end
      if (cal_q && cal_done)
        cal_q <= 1'b0;
      if (az_q && az_done)
        az_q <= 1'b0;
      if (commit) begin
        if (!widx[3]) begin
          if (sec != 2'd3)
            imem[{widx[2:0], sec}] <= merge(imem[{widx[2:0], sec}], wd_q, wide, whi);
        end else begin
          case (widx)
            `ADCS_IDX_CFG: begin
              cfg_q <= merge(cfg_q, wd_q, wide, whi) &
                       ~(16'h0001 << `ADCS_C_RESET) & ~(16'h0001 << `ADCS_C_CAL) &
                       ~(16'h0001 << `ADCS_C_AZ);
              if (!whi || wide) begin
                if (wd_q[`ADCS_C_CAL])
                  cal_q <= 1'b1;
                if (wd_q[`ADCS_C_AZ])
                  az_q <= 1'b1;
                if (wd_q[`ADCS_C_RESET])
                  cfg_q[`ADCS_C_START] <= 1'b0;
              end
            end
            `ADCS_IDX_IEN:   ien_q   <= merge(ien_q, wd_q, wide, whi);
            `ADCS_IDX_TIMER: timer_q <= merge(timer_q, wd_q, wide, whi);
            default: ;
          endcase
        end
      end
      // Pause clears start; set by host again to resume
      if (st_q == S_NEXT && !halt && iw[`ADCS_I_PAUSE])
        cfg_q[`ADCS_C_START] <= 1'b0;
    end
  end

  // Status: a read clears, but a new event in that cycle wins
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      stat_q    <= 8'h00;
      limstat_q <= 16'h0000;
      irq_q     <= 1'b0;
    end else if (soft_rst) begin
      stat_q    <= 8'h00;
      limstat_q <= 16'h0000;
      irq_q     <= 1'b0;
    end else begin
      stat_q <= ((rd_low && idx_s == `ADCS_IDX_STAT) ? 8'h00 : stat_q) | ev;
      if (rd_low && idx_s == `ADCS_IDX_LIMSTAT)
        limstat_q <= 16'h0000;
      if (st_q == S_NEXT && !halt && iw[`ADCS_I_WDOG]) begin
        if (hit1)
          limstat_q[slot_q] <= 1'b1;
        if (hit2)
          limstat_q[{1'b1, slot_q}] <= 1'b1;
      end
      irq_q <= |(stat_q & ien_q[7:0]);
    end
  end

  // FIFO storage
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wptr_q <= {(PTR_W+1){1'b0}};
      rptr_q <= {(PTR_W+1){1'b0}};
    end else if (soft_rst) begin
      wptr_q <= {(PTR_W+1){1'b0}};
      rptr_q <= {(PTR_W+1){1'b0}};
    end else begin
      if (fpush) begin
        fmem[wptr_q[PTR_W-1:0]] <= bo_data;
        wptr_q <= wptr_q + 1'b1;
      end
      if (fpop)
        rptr_q <= rptr_q + 1'b1;
    end
  end

  // Instruction sequencer; every step waits while chip select is held
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q   <= S_IDLE;
      slot_q <= 3'd0;
      cnt_q  <= 22'd0;
      res_q  <= 13'h0000;
      creq_q <= 1'b0;
    end else if (soft_rst) begin
      st_q   <= S_IDLE;
      slot_q <= 3'd0;
      creq_q <= 1'b0;
    end else if (!halt) begin
      case (st_q)
        S_IDLE: begin
          if (run && !cal_q && !az_q) begin
            if (iw[`ADCS_I_TIMER]) begin
              cnt_q <= {1'b0, timer_q, {`ADCS_TMR_SHIFT{1'b0}}} + `ADCS_TMR_OVH;
              st_q  <= S_WAIT;
            end else begin
              creq_q <= 1'b1;
              st_q   <= S_CONV;
            end
          end
        end
        S_WAIT: begin
          if (cnt_q <= 22'd1) begin
            creq_q <= 1'b1;
            st_q   <= S_CONV;
          end else begin
            cnt_q <= cnt_q - 22'd1;
          end
        end
        S_CONV: begin
          if (conv_done) begin
            creq_q <= 1'b0;
            res_q  <= conv_result;
            st_q   <= iw[`ADCS_I_WDOG] ? S_NEXT : S_PUSH;
          end
        end
        S_PUSH: begin
          // Buffer back-pressure stalls the sequencer, so no result drops
          if (bi_ready)
            st_q <= S_NEXT;
        end
        S_NEXT: begin
          slot_q <= iw[`ADCS_I_LOOP] ? 3'd0 : slot_q + 3'd1;
          st_q   <= S_IDLE;
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  // Outputs; the converter channel fields come from instruction section zero
  assign conv_req  = creq_q;
  assign conv_sel8 = iw[`ADCS_I_SEL8] | iw[`ADCS_I_WDOG];
  assign conv_acq  = iw[`ADCS_I_ACQ+3:`ADCS_I_ACQ];
  assign conv_pos  = iw[`ADCS_I_POS+2:`ADCS_I_POS];
  assign conv_neg  = iw[`ADCS_I_NEG+2:`ADCS_I_NEG];
  assign cal_req   = cal_q;
  assign az_req    = az_q;
  assign data_out  = dout_q;
  assign data_oe_b = oe_b_q;
  assign irq_b     = ~irq_q;

endmodule

// >>> testbench/adcs_conv_model.sv
`timescale 1ns/1ns
module adcs_conv_model #(
  parameter LAT = 5
) (
  input  wire        ref_clk,
  input  wire        rst_b,
  input  wire        cs_b,
  input  wire        conv_req,
  input  wire [2:0]  conv_pos,
  input  wire [2:0]  conv_neg,
  output reg         conv_done,
  output wire [12:0] conv_result,
  input  wire        cal_req,
  input  wire        az_req,
  output reg         cal_done,
  output reg         az_done
);
  reg  [1:0]  cs_q;
  reg  [3:0]  cnt_q;
  reg  [3:0]  tcnt_q;
  wire [12:0] val = {conv_pos, conv_neg, 7'h53};
  wire        busy = (cal_req && !cal_done) || (az_req && !az_done);
  // Result is only meaningful beside done
  assign conv_result = conv_done ? val : ~val;
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cs_q <= 2'b11;
      cnt_q <= 4'h0;
      tcnt_q <= 4'h0;
      conv_done <= 1'b0;
      cal_done <= 1'b0;
      az_done <= 1'b0;
    end else begin
      cs_q <= {cs_q[0], cs_b};
      // Same two-flop delay as the block, so both halt on the same edges
      if (cs_q[1]) begin
        conv_done <= 1'b0;
        cal_done <= 1'b0;
        az_done <= 1'b0;
        cnt_q <= (conv_req && !conv_done) ? cnt_q + 4'h1 : 4'h0;
        tcnt_q <= busy ? tcnt_q + 4'h1 : 4'h0;
        if (conv_req && !conv_done && cnt_q == LAT) begin
          conv_done <= 1'b1;
          cnt_q <= 4'h0;
        end
        if (busy && tcnt_q == LAT) begin
          cal_done <= cal_req;
          az_done <= az_req;
          tcnt_q <= 4'h0;
        end
      end
    end
  end
endmodule

// >>> testbench/adcs_sequencer_bench.sv
`timescale 1ns/1ns
`include "adcs_defines.vh"
bind adcs_sequencer adcs_sequencer_sva adcs_sequencer_sva_inst (.ref_clk, .rst_b, .cs_b, .rd_b, .wr_b,
  .data_out, .data_oe_b, .bus_width_select, .irq_b, .conv_req, .conv_sel8, .conv_acq, .conv_pos,
  .conv_neg, .conv_done, .cal_req, .az_req, .cal_done, .az_done);
module adcs_sequencer_bench;
  reg         ref_clk;
  reg         rst_b;
  reg         cs_b;
  reg         rd_b;
  reg         wr_b;
  reg  [4:0]  addr;
  reg  [15:0] data_in;
  reg         bus_width_select;
  wire [15:0] data_out;
  wire        data_oe_b;
  wire        irq_b;
  wire        conv_req;
  wire        conv_sel8;
  wire [3:0]  conv_acq;
  wire [2:0]  conv_pos;
  wire [2:0]  conv_neg;
  wire        conv_done;
  wire [12:0] conv_result;
  wire        cal_req;
  wire        az_req;
  wire        cal_done;
  wire        az_done;
  int         miscompares = 0;
  int         checks = 0;
  reg  [15:0] d;

  adcs_sequencer adcs_sequencer_inst (.ref_clk, .rst_b, .cs_b, .rd_b, .wr_b, .addr, .data_in, .data_out,
    .data_oe_b, .bus_width_select, .irq_b, .conv_req, .conv_sel8, .conv_acq, .conv_pos, .conv_neg,
    .conv_done, .conv_result, .cal_req, .az_req, .cal_done, .az_done);
  adcs_conv_model adcs_conv_model_inst (.ref_clk, .rst_b, .cs_b, .conv_req, .conv_pos, .conv_neg,
    .conv_done, .conv_result, .cal_req, .az_req, .cal_done, .az_done);

  task automatic print_verdict;
    if (miscompares == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input [15:0] exp, input [15:0] got);
    checks++;
    if (got !== exp) begin
      $display("FAIL %s expected %h seen %h", nm, exp, got);
      miscompares++;
    end
  endtask

  task automatic bound(input int n);
    if (n >= 3000) begin
      miscompares++;
      $display("FAIL wait expected event seen timeout");
      print_verdict;
    end
  endtask

  // One byte cycle; strobes kept well over three clocks low and high
  task automatic acc(input bit w, input [3:0] idx, input bit hi, input [7:0] wd, output [15:0] rd);
    @(posedge ref_clk);
    addr <= {idx, hi};
    data_in <= {8'h00, wd};
    cs_b <= 1'b0;
    wr_b <= !w;
    rd_b <= w;
    repeat (5) @(posedge ref_clk);
    @(negedge ref_clk);
    rd = data_out;
    @(posedge ref_clk);
    cs_b <= 1'b1;
    wr_b <= 1'b1;
    rd_b <= 1'b1;
    data_in <= ~data_in;
    repeat (4) @(posedge ref_clk);
  endtask

  task automatic wr16(input [3:0] idx, input [15:0] v);
    reg [15:0] x;
    acc(1'b1, idx, 1'b0, v[7:0], x);
    acc(1'b1, idx, 1'b1, v[15:8], x);
  endtask

  task automatic rd16(input [3:0] idx, output [15:0] v);
    reg [15:0] lo;
    reg [15:0] hi;
    acc(1'b0, idx, 1'b0, 8'h00, lo);
    acc(1'b0, idx, 1'b1, 8'h00, hi);
    v = {hi[7:0], lo[7:0]};
  endtask

  task automatic wait_req(input bit lvl, inout int n);
    while (conv_req !== lvl && n < 3000) begin
      @(negedge ref_clk);
      n++;
    end
    bound(n);
  endtask

  task automatic period(output int p);
    int n;
    n = 0;
    wait_req(1'b0, n);
    wait_req(1'b1, n);
    n = 0;
    wait_req(1'b0, n);
    wait_req(1'b1, n);
    p = n;
  endtask

  task automatic test_reset;
    rd16(4'h8, d);
    chk("cfg", `ADCS_CFG_RST, d);
    rd16(4'h9, d);
    chk("ien", `ADCS_IEN_RST, d);
    rd16(4'hb, d);
    chk("timer", `ADCS_TIMER_RST, d);
    rd16(4'he, d);
    chk("unmapped", 16'h0000, d);
    wr16(4'h9, 16'h5a3c);
    acc(1'b1, 4'h9, 1'b1, 8'h81, d);
    rd16(4'h9, d);
    chk("ien bytes", 16'h813c, d);
    wr16(4'h9, 16'h0000);
    chk("irq_b idle", 16'h0001, {15'h0000, irq_b});
  endtask

  task automatic test_timer;
    int p0;
    int p1;
    acc(1'b1, 4'h8, 1'b0, 8'h02, d);
    wr16(4'hb, 16'h0002);
    wr16(4'h0, 16'h0001);
    acc(1'b1, 4'h8, 1'b0, 8'h01, d);
    period(p0);
    acc(1'b1, 4'h8, 1'b0, 8'h02, d);
    wr16(4'h0, 16'h0201);
    acc(1'b1, 4'h8, 1'b0, 8'h01, d);
    period(p1);
    chk("timer gap", 16'd66, 16'(p1 - p0));
    acc(1'b1, 4'h8, 1'b0, 8'h02, d);
  endtask

  task automatic wait_irq;
    int n;
    n = 0;
    while (irq_b !== 1'b0 && n < 3000) begin
      @(negedge ref_clk);
      n++;
    end
    bound(n);
  endtask

  task automatic test_run;
    wr16(4'h0, 16'h502c);
    wr16(4'h1, 16'h0409);
    wr16(4'h9, 16'h1804);
    // Slot zero is current after the soft reset, so its fields show now
    chk("slot fields", 16'h0159, {5'h00, conv_sel8, conv_acq, conv_pos, conv_neg});
    acc(1'b1, 4'h8, 1'b0, 8'h01, d);
    wait_irq;
    rd16(4'ha, d);
    chk("level source", 16'h0001, {15'h0000, d[2]});
    // Sequencer keeps running while the results are taken out
    rd16(4'hc, d);
    chk("fifo 0", 16'h0cd3, d);
    rd16(4'hc, d);
    chk("fifo 1", 16'h2085, d);
    rd16(4'hc, d);
    chk("fifo 2", 16'h0cd3, d);
    acc(1'b1, 4'h8, 1'b0, 8'h02, d);
  endtask

  task automatic test_cal;
    wr16(4'h9, 16'h0000);
    acc(1'b1, 4'h8, 1'b0, 8'h08, d);
    repeat (40) @(posedge ref_clk);
    acc(1'b1, 4'h8, 1'b0, 8'h04, d);
    repeat (40) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("irq_b masked", 16'h0001, {15'h0000, irq_b});
    wr16(4'h9, 16'h0018);
    @(negedge ref_clk);
    chk("irq_b enabled", 16'h0000, {15'h0000, irq_b});
    acc(1'b0, 4'ha, 1'b0, 8'h00, d);
    chk("status", 16'h0018, d);
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("irq_b cleared", 16'h0001, {15'h0000, irq_b});
  endtask

  task automatic test_wdog;
    acc(1'b1, 4'h8, 1'b1, 8'h01, d);
    wr16(4'h0, 16'h0204);
    rd16(4'h0, d);
    chk("limit one", 16'h0204, d);
    acc(1'b1, 4'h8, 1'b1, 8'h02, d);
    wr16(4'h0, 16'h0003);
    acc(1'b1, 4'h8, 1'b1, 8'h00, d);
    wr16(4'h0, 16'h0801);
    wr16(4'h9, 16'h0001);
    acc(1'b1, 4'h8, 1'b0, 8'h01, d);
    wait_irq;
    // Result 5 is above limit one (4) and not below limit two (3)
    rd16(4'hd, d);
    chk("limit status", 16'h0001, d);
    rd16(4'hc, d);
    chk("watchdog not stored", 16'h0000, d);
    acc(1'b1, 4'h8, 1'b0, 8'h02, d);
  endtask

  task automatic test_wide;
    wr16(4'hb, 16'hff00);
    @(posedge ref_clk);
    bus_width_select <= 1'b0;
    acc(1'b1, 4'hb, 1'b0, 8'h5a, d);
    acc(1'b0, 4'hb, 1'b0, 8'h00, d);
    chk("word write", 16'h005a, d);
    @(posedge ref_clk);
    bus_width_select <= 1'b1;
    repeat (3) @(posedge ref_clk);
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  initial begin
    rst_b = 1'b0;
    cs_b = 1'b1;
    rd_b = 1'b1;
    wr_b = 1'b1;
    addr = 5'h00;
    data_in = 16'h0000;
    bus_width_select = 1'b1;
    repeat (10) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge ref_clk);
    test_reset;
    test_timer;
    test_run;
    test_cal;
    test_wdog;
    test_wide;
    print_verdict;
  end
endmodule

// >>> testbench/adcs_sequencer_sva.sv
`timescale 1ns/1ns
module adcs_sequencer_sva (
  input wire        ref_clk,
  input wire        rst_b,
  input wire        cs_b,
  input wire        rd_b,
  input wire        wr_b,
  input wire [15:0] data_out,
  input wire        data_oe_b,
  input wire        bus_width_select,
  input wire        irq_b,
  input wire        conv_req,
  input wire        conv_sel8,
  input wire [3:0]  conv_acq,
  input wire [2:0]  conv_pos,
  input wire [2:0]  conv_neg,
  input wire        conv_done,
  input wire        cal_req,
  input wire        az_req,
  input wire        cal_done,
  input wire        az_done
);
  reg [2:0] wr_quiet_q;
  // A soft reset may drop a request, so holds are judged only away from writes
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_quiet_q <= 3'h0;
    end else if (!wr_b) begin
      wr_quiet_q <= 3'h0;
    end else if (wr_quiet_q != 3'h7) begin
      wr_quiet_q <= wr_quiet_q + 3'h1;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  a_read_enable: assert property (data_oe_b == !(!$past(rd_b, 3) && !$past(cs_b, 3)))
    else $error("data_oe_b does not follow the read strobe");
  a_req_holds: assert property (conv_req && !conv_done && wr_quiet_q >= 3'h6 |=> conv_req)
    else $error("conv_req dropped before conv_done");
  a_req_ends: assert property (conv_req && conv_done |-> ##[1:12] !conv_req)
    else $error("conv_req kept after conv_done");
  a_cal_holds: assert property (cal_req && !cal_done && wr_quiet_q >= 3'h6 |=> cal_req)
    else $error("cal_req dropped early");
  a_az_holds: assert property (az_req && !az_done && wr_quiet_q >= 3'h6 |=> az_req)
    else $error("az_req dropped early");
  a_cs_freeze: assert property ($rose(conv_req) |-> $past(cs_b, 3))
    else $error("conversion started while selected");
  a_fields_stable: assert property (conv_req && $past(conv_req) |-> $stable({conv_sel8, conv_acq, conv_pos, conv_neg}))
    else $error("channel fields moved during conversion");
  a_byte_upper: assert property (bus_width_select && !data_oe_b |-> data_out[15:8] == 8'h00)
    else $error("upper byte not zero in byte mode");
  a_data_hold: assert property (data_oe_b && $past(data_oe_b) |-> $stable(data_out))
    else $error("data_out changed outside a read");
  c_conv: cover property (conv_req && conv_done);
  c_irq: cover property ($fell(irq_b));
  c_cal: cover property (cal_req && cal_done);
endmodule
